//--- core/pviu_regs.svh
`ifndef PVIU_REGS_SVH
`define PVIU_REGS_SVH
// APB word offsets and byte addresses
`define PVIU_MASK_OFS 8'h08
`define PVIU_PEND_OFS 8'h09
`define PVIU_MASK_ADDR 12'h020
`define PVIU_PEND_ADDR 12'h024
`define PVIU_GEN_ADDR 12'h040
`define PVIU_STAT_ADDR 12'h044
`define PVIU_SERVED_ADDR 12'h048
// Vector table
`define PVIU_VEC_BASE 16'h2000
// Source numbers
`define PVIU_SRC_CMPPIN 3'h3
`define PVIU_SRC_CAPDATA 3'h2
`define PVIU_SRC_CAP0 3'h4
`define PVIU_SRC_SWTMR 3'h5
// Reset values
`define PVIU_MASK_RST 8'h00
`define PVIU_PEND_RST 8'h00
`define PVIU_PSW_FLAGS_RST 7'h00
// Status word fields
`define PVIU_PSW_MASK_MSB 7
`define PVIU_PSW_F0_BIT 8
`define PVIU_PSW_GE_BIT 9
`define PVIU_PSW_FHI_LSB 10
`define PVIU_PSW_FHI_MSB 15
`endif

//--- core/pviu_pkg.sv
package pviu_pkg;
  typedef logic [7:0] pviu_byte_t;
  typedef logic [15:0] pviu_word_t;
  typedef enum logic [1:0] {
    PVIU_IDLE = 2'b00,
    PVIU_CALL = 2'b01,
    PVIU_HOLD = 2'b10
  } pviu_state_e;
endpackage

//--- core/pviu_sel_if.sv
`timescale 1ns/10ps
interface pviu_sel_if;
  logic [7:0] req;
  logic hit;
  logic [2:0] idx;
  modport top (output req, input hit, input idx);
  modport sel (input req, output hit, output idx);
endinterface

//--- core/pviu_prio_sel.sv
`timescale 1ns/10ps
module pviu_prio_sel (
  pviu_sel_if.sel s
);
  import pviu_pkg::*;
  // ----------------------------------------
  // Highest set bit wins
  // ----------------------------------------
  always_comb begin
    s.hit = 1'b0;
    s.idx = 3'd0;
    for (int i = 0; i < 8; i++) begin
      if (s.req[i]) begin
        s.hit = 1'b1;
        s.idx = 3'(i);
      end
    end
  end
endmodule

//--- core/pviu_top.sv
`timescale 1ns/10ps
`include "pviu_regs.svh"
module pviu_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_boundary,
  input wire logic flag_push_instruction,
  input wire logic flag_pop_instruction,
  input wire logic enable_interrupts_instruction,
  input wire logic disable_interrupts_instruction,
  input wire logic [15:0] psw_pop_data,
  input wire logic [15:0] current_pc,
  input wire logic rmw_wr,
  input wire logic [7:0] rmw_and,
  input wire logic [7:0] rmw_or,
  input wire logic [7:0] hw_event,
  input wire logic cmd_exec,
  input wire logic cmd_drives_pin,
  input wire logic capture_fifo_data,
  input wire logic capture_pin_zero,
  output logic int_call,
  output logic [15:0] int_vector,
  output logic [15:0] push_data,
  output logic push_valid,
  output logic [15:0] processor_status_word,
  output logic global_enable
);
  import pviu_pkg::*;

  pviu_byte_t mask_r;
  pviu_byte_t pend_r;
  logic [6:0] flags_r;
  logic gen_r;
  logic cap0_q_r;
  logic fifo_q_r;
  logic block_r;
  pviu_state_e state_r;
  logic [7:0] served_r;
  pviu_byte_t hw_set;
  pviu_byte_t pend_nxt;
  logic wr_acc;
  logic rd_acc;
  logic take;
  logic mask_wr;
  logic pend_wr;
  logic gen_wr;
  pviu_word_t vec_nxt;
  pviu_word_t psw_now;
  pviu_byte_t pop_mask;
  logic pop_ge;
  logic [6:0] pop_flags;
  pviu_sel_if sel_bus ();

  // ----------------------------------------
  // Event sources
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cap0_q_r <= 1'b0;
      fifo_q_r <= 1'b0;
    end else begin
      cap0_q_r <= capture_pin_zero;
      fifo_q_r <= capture_fifo_data;
    end
  end

  always_comb begin
    hw_set = hw_event;
    hw_set[`PVIU_SRC_CMPPIN] = hw_event[`PVIU_SRC_CMPPIN] | (cmd_exec & cmd_drives_pin);
    hw_set[`PVIU_SRC_SWTMR] = hw_event[`PVIU_SRC_SWTMR] | (cmd_exec & ~cmd_drives_pin);
    hw_set[`PVIU_SRC_CAPDATA] = hw_event[`PVIU_SRC_CAPDATA] | (capture_fifo_data & ~fifo_q_r);
    hw_set[`PVIU_SRC_CAP0] = hw_event[`PVIU_SRC_CAP0] | (capture_pin_zero & ~cap0_q_r);
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~penable & ~pwrite;
  assign take = (state_r == PVIU_IDLE) & instr_boundary & ~block_r & gen_r & sel_bus.hit;
  assign mask_wr = wr_acc & (paddr == `PVIU_MASK_ADDR);
  assign pend_wr = wr_acc & (paddr == `PVIU_PEND_ADDR);
  assign gen_wr = wr_acc & (paddr == `PVIU_GEN_ADDR);

  // ----------------------------------------
  // Priority select
  // ----------------------------------------
  // Bit equals priority
  assign sel_bus.req = pend_r & mask_r;
  pviu_prio_sel u_sel (
    .s(sel_bus.sel)
  );

  // ----------------------------------------
  // Vector address
  // ----------------------------------------
  // Base plus two per source
  assign vec_nxt = 16'(`PVIU_VEC_BASE + {12'h000, sel_bus.idx, 1'b0});

  // ----------------------------------------
  // Pending register
  // ----------------------------------------
  always_comb begin
    pend_nxt = pend_r;
    if (pend_wr) begin
      pend_nxt = pwdata[7:0];
    end
    if (rmw_wr) begin
      pend_nxt = (pend_nxt & rmw_and) | rmw_or;
    end
    if (take) begin
      pend_nxt[sel_bus.idx] = 1'b0;
    end
    pend_nxt = pend_nxt | hw_set;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_r <= `PVIU_PEND_RST;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // ----------------------------------------
  // Popped status word fields
  // ----------------------------------------
  assign pop_mask = psw_pop_data[`PVIU_PSW_MASK_MSB:0];
  assign pop_ge = psw_pop_data[`PVIU_PSW_GE_BIT];
  assign pop_flags = {psw_pop_data[`PVIU_PSW_FHI_MSB:`PVIU_PSW_FHI_LSB],
    psw_pop_data[`PVIU_PSW_F0_BIT]};
  assign psw_now = {flags_r[6:1], gen_r, flags_r[0], mask_r};

  // ----------------------------------------
  // Status word, mask and global enable
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask_r <= `PVIU_MASK_RST;
      flags_r <= `PVIU_PSW_FLAGS_RST;
      gen_r <= 1'b0;
    end else if (flag_push_instruction) begin
      mask_r <= `PVIU_MASK_RST;
      flags_r <= `PVIU_PSW_FLAGS_RST;
      gen_r <= 1'b0;
    end else if (flag_pop_instruction) begin
      mask_r <= pop_mask;
      gen_r <= pop_ge;
      flags_r <= pop_flags;
    end else begin
      if (mask_wr) begin
        mask_r <= pwdata[7:0];
      end
      if (enable_interrupts_instruction) begin
        gen_r <= 1'b1;
      end else if (disable_interrupts_instruction) begin
        gen_r <= 1'b0;
      end else if (gen_wr) begin
        gen_r <= pwdata[0];
      end
    end
  end

  // ----------------------------------------
  // Interrupt-call sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= PVIU_IDLE;
      int_call <= 1'b0;
      int_vector <= `PVIU_VEC_BASE;
      push_data <= 16'h0000;
      push_valid <= 1'b0;
      served_r <= 8'h00;
    end else begin
      int_call <= 1'b0;
      push_valid <= 1'b0;
      unique case (state_r)
        PVIU_IDLE: begin
          if (take) begin
            int_call <= 1'b1;
            push_valid <= 1'b1;
            push_data <= current_pc;
            int_vector <= vec_nxt;
            served_r <= {5'h00, sel_bus.idx};
            state_r <= PVIU_CALL;
          end
        end
        PVIU_CALL: begin
          state_r <= PVIU_HOLD;
        end
        PVIU_HOLD: begin
          if (instr_boundary) begin
            state_r <= PVIU_IDLE;
          end
        end
        default: begin
          state_r <= PVIU_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // One-instruction lockout
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      block_r <= 1'b0;
    end else if (flag_push_instruction || flag_pop_instruction) begin
      block_r <= 1'b1;
    end else if (take) begin
      block_r <= 1'b1;
    end else if (instr_boundary && state_r == PVIU_IDLE) begin
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        unique case (paddr)
          `PVIU_MASK_ADDR, `PVIU_PEND_ADDR, `PVIU_GEN_ADDR,
          `PVIU_STAT_ADDR, `PVIU_SERVED_ADDR: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      if (rd_acc) begin
        unique case (paddr)
          `PVIU_MASK_ADDR: prdata <= {24'h00_0000, mask_r};
          `PVIU_PEND_ADDR: prdata <= {24'h00_0000, pend_r};
          `PVIU_GEN_ADDR: prdata <= {31'h0000_0000, gen_r};
          `PVIU_STAT_ADDR: prdata <= {16'h0000, processor_status_word};
          `PVIU_SERVED_ADDR: prdata <= {24'h00_0000, served_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      processor_status_word <= 16'h0000;
      global_enable <= 1'b0;
    end else begin
      processor_status_word <= psw_now;
      global_enable <= gen_r;
    end
  end
endmodule

//--- sim/pviu_core_model.sv
`timescale 1ns/10ps
module pviu_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic int_call,
  input wire logic [15:0] int_vector,
  output logic instr_boundary,
  output logic [15:0] current_pc
);
  logic [1:0] cnt_r;
  logic [15:0] vec_tbl [8];
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      vec_tbl[i] = 16'h0400 + 16'(i * 32);
    end
  end
  // ------
  // Sequencer
  // ------
  // boundary between instructions
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
      instr_boundary <= 1'b0;
      current_pc <= 16'h0100;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      instr_boundary <= slow ? (cnt_r == 2'h3) : cnt_r[0];
      if (int_call) begin
        current_pc <= vec_tbl[int_vector[3:1]];
      end else if (instr_boundary) begin
        current_pc <= current_pc + 16'h0002;
      end
    end
  end
endmodule

//--- sim/pviu_top_assertions.sv
`timescale 1ns/10ps
module pviu_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic instr_boundary,
  input wire logic flag_push_instruction,
  input wire logic flag_pop_instruction,
  input wire logic enable_interrupts_instruction,
  input wire logic [15:0] current_pc,
  input wire logic int_call,
  input wire logic [15:0] int_vector,
  input wire logic [15:0] push_data,
  input wire logic push_valid,
  input wire logic [15:0] processor_status_word,
  input wire logic global_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ------
  // Checks
  // ------
  call_push_a: assert property
    (int_call |-> push_valid && push_data == $past(current_pc)) else $error("bad pc push");
  vec_form_a: assert property
    (int_call |-> int_vector[15:4] == 12'h200 && !int_vector[0]) else $error("bad vector");
  no_chain_a: assert property
    (int_call |=> !int_call [*2]) else $error("call chained");
  call_edge_a: assert property
    (int_call |-> $past(instr_boundary)) else $error("call off boundary");
  pop_lock_a: assert property
    (flag_pop_instruction ##1 instr_boundary |=> !int_call) else $error("call after pop");
  push_clr_a: assert property
    (flag_push_instruction && !enable_interrupts_instruction |-> ##[1:2]
    processor_status_word == 16'h0000) else $error("status not cleared");
  ge_set_a: assert property
    (enable_interrupts_instruction && !flag_push_instruction && !flag_pop_instruction
    |-> ##[1:2] global_enable) else $error("enable not set");
  apb_rdy_a: assert property
    (psel && !penable |=> pready ##1 !pready) else $error("bad ready");
endmodule
bind pviu_top pviu_chk u_pviu_chk (.*);

//--- sim/tb_pviu_top.sv
`timescale 1ns/10ps
module tb_pviu_top;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, instr_boundary, slow, e;
  logic flag_push_instruction, flag_pop_instruction, enable_interrupts_instruction;
  logic disable_interrupts_instruction, rmw_wr, cmd_exec, cmd_drives_pin;
  logic capture_fifo_data, capture_pin_zero, int_call, push_valid, global_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] psw_pop_data, current_pc, int_vector, push_data, processor_status_word;
  logic [7:0] rmw_and, rmw_or, hw_event;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  pviu_top u_pviu_top (.*);
  pviu_core_model u_pviu_core_model (.*);
  // ------
  // Tasks
  // ------
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk("reg", q, x);
  endtask
  task ins(input logic en);
    @(posedge ref_clk);
    enable_interrupts_instruction <= en;
    disable_interrupts_instruction <= !en;
    @(posedge ref_clk);
    {enable_interrupts_instruction, disable_interrupts_instruction} <= 2'b00;
  endtask
  task wait_call(input logic [15:0] x);
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      #1;
      i++;
    end while (int_call !== 1'b1 && i < 60);
    chk("call", int_call, 1'b1);
    chk("vector", int_vector, x);
  endtask
  task align;
    do begin
      @(posedge ref_clk);
      #1;
    end while (instr_boundary !== 1'b1);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ------
  // Run
  // ------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    rst = 1'b1;
    slow = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, rmw_wr, rmw_and, rmw_or, hw_event} = '0;
    {flag_push_instruction, flag_pop_instruction, enable_interrupts_instruction} = '0;
    {disable_interrupts_instruction, psw_pop_data, cmd_exec, cmd_drives_pin} = '0;
    {capture_fifo_data, capture_pin_zero} = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(12'h020, '0);
    rd(12'h024, '0);
    apb(1'b1, 12'h024, 32'h0000_00A5);
    rd(12'h024, 32'h0000_00A5);
    rd(12'h0FC, '0);
    chk("slverr", e, 1'b1);
    apb(1'b1, 12'h024, '0);
    $display("registers done");
    @(posedge ref_clk);
    {cmd_exec, cmd_drives_pin, capture_fifo_data, capture_pin_zero} <= 4'hF;
    hw_event <= 8'h80;
    @(posedge ref_clk);
    cmd_drives_pin <= 1'b0;
    hw_event <= 8'h00;
    @(posedge ref_clk);
    cmd_exec <= 1'b0;
    rd(12'h024, 32'h0000_00BC);
    @(posedge ref_clk);
    {rmw_wr, rmw_and, rmw_or, hw_event} <= {1'b1, 8'hF7, 8'h01, 8'h40};
    @(posedge ref_clk);
    rmw_wr <= 1'b0;
    hw_event <= 8'h00;
    rd(12'h024, 32'h0000_00F5);
    $display("events done");
    apb(1'b1, 12'h024, 32'h0000_00FF);
    apb(1'b1, 12'h020, 32'h0000_00FF);
    slow <= 1'b1;
    ins(1'b1);
    for (int i = 7; i >= 0; i--) begin
      wait_call(16'(16'h2000 + 2 * i));
    end
    rd(12'h024, '0);
    slow <= 1'b0;
    $display("priority done");
    ins(1'b0);
    apb(1'b1, 12'h024, 32'h0000_00FF);
    apb(1'b1, 12'h020, 32'h0000_0004);
    ins(1'b1);
    wait_call(16'h2004);
    rd(12'h024, 32'h0000_00FB);
    $display("mask done");
    align();
    @(posedge ref_clk);
    flag_push_instruction <= 1'b1;
    @(posedge ref_clk);
    flag_push_instruction <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("status", processor_status_word, '0);
    chk("enable", global_enable, 1'b0);
    align();
    @(posedge ref_clk);
    flag_pop_instruction <= 1'b1;
    psw_pop_data <= 16'h0281;
    @(posedge ref_clk);
    flag_pop_instruction <= 1'b0;
    wait_call(16'h200E);
    rd(12'h020, 32'h0000_0081);
    $display("status done");
    finish_test();
  end
endmodule
